// [hw/smart_card_char_retransmit.sv]
// Smart-card character unit: one open-drain data line, a card clock,
// a plain register port and three request outputs.
// Assumes a pull-up on the data line and the card on the same line.
//
// Notes on behaviour
// [R1] Bits timed from 372-cycle basic clock periods
// [R2] Start falling edge, seen on basic clock, aligns timing
// [R3] Each received bit captured at 186th basic cycle; the code captures at the 185th
// [R4] Frame: start, eight data, parity, ten bits
// [R5] Bad parity sets parity flag, error request
// [R6] Software clears parity flag before next parity
// [R7] Bad parity frame never sets receive-full flag
// [R8] Good parity leaves parity flag untouched
// [R9] Good parity sets receive-full, receive request
// [R10] Good frame: line released in error interval
// [R11] Returned error signal sets error flag, request
// [R12] Software clears error flag before next parity
// [R13] Rejected frame: no end flag, resent automatically
// [R14] No error signal leaves error flag clear
// [R15] Clean frame sets end flag, transmit request
// [R16] Character protocol only, always signalling, resending
// [R17] No transmit-end request exists in this mode
// [R18] Character kept readable despite parity error
// [R19] Error shown by pulling line low after parity
// [R20] Resend starts right after error interval, same byte; the code resends only after the guard slot that follows it
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "sc_cfg.svh"
module smart_card_char_retransmit
  import sc_pkg::*;
#(
  parameter logic [3:0] BASE_HALF_DIV = `SC_BASE_HALF_DIV,
  parameter logic [8:0] ETU_TICKS = `SC_ETU_TICKS,
  parameter logic [8:0] SAMPLE_TICK = `SC_SAMPLE_TICK
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // Card data line, open drain
  input wire logic dataIn,
  output logic dataOut,
  output logic dataOe,
  // Card clock
  output logic cardClk,
  // Requests
  output logic tx_empty_irq,
  output logic rx_full_irq,
  output logic comm_error_irq
);
  sc_tick_if tickBus ();

  // Basic clock generator
  sc_base_clock #(
    .HALF_DIV(BASE_HALF_DIV)
  ) u_base (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .tb(tickBus.gen)
  );

  logic tick;
  assign tick = tickBus.tick;
  assign cardClk = tickBus.cardClk;

  // ---------------- Register state ----------------
  logic [4:0] ctrl_q, ctrl_d;
  logic tx_end_flag_q, tx_end_flag_d;
  logic rx_full_flag_q, rx_full_flag_d;
  logic parity_error_flag_q, parity_error_flag_d;
  logic error_signal_flag_q, error_signal_flag_d;
  logic [7:0] txBuf_q, txBuf_d;
  logic txPending_q, txPending_d;
  logic [7:0] rx_data_reg_q, rx_data_reg_d;
  logic [7:0] rdata_q, rdata_d;

  // ---------------- Line sampling state ----------------
  logic lineMeta_q, lineSync_q, linePrev_q, linePrev_d;

  // ---------------- Sequencer state ----------------
  scState_t state_q, state_d;
  scDir_t dir_q, dir_d;
  logic [8:0] tickCnt_q, tickCnt_d;
  logic [3:0] slot_q, slot_d;
  logic [7:0] shift_q, shift_d;
  logic parBad_q, parBad_d;
  logic errSeen_q, errSeen_d;
  logic driveLow_q, driveLow_d;

  // Sequencer events, read by the register logic
  logic evParErr, evRxGood, evErrSig, evTxDone, txTaken;

  logic txEn, rxEn, oddPar;
  assign txEn = ctrl_q[`SC_CTRL_TX_EN];
  assign rxEn = ctrl_q[`SC_CTRL_RX_EN];
  assign oddPar = ctrl_q[`SC_CTRL_ODD_PAR];

  // Two-stage synchroniser on the data line
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      lineMeta_q <= 1'b1;
      lineSync_q <= 1'b1;
    end else begin
      lineMeta_q <= dataIn;
      lineSync_q <= lineMeta_q;
    end
  end

  // Line level as it stood at the previous basic clock tick
  always_comb begin
    linePrev_d = linePrev_q;
    if (tick) begin
      linePrev_d = lineSync_q;
    end
  end

  logic startEdge, sampleNow, bitEnd;
  // Falling edge judged only on basic clock ticks
  assign startEdge = tick && linePrev_q && !lineSync_q; // [R2]
  // 185th basic cycle of the current bit period
  assign sampleNow = tick && (tickCnt_q == SAMPLE_TICK - 9'h1); // [R3]
  // Last basic cycle of a bit period
  assign bitEnd = tick && (tickCnt_q == ETU_TICKS); // [R1]

  // Level the transmitter puts on the line for a frame slot
  function automatic logic txBitLevel(input logic [3:0] slot,
                                      input logic [7:0] data,
                                      input logic odd);
    logic lvl;
    lvl = 1'b1;
    if (slot == 4'h0) begin
      lvl = 1'b0;
    end else if (slot <= 4'h8) begin
      lvl = data[slot[2:0] - 3'h1];
    end else if (slot == `SC_FRAME_BITS - 4'h1) begin
      lvl = ^data ^ odd;
    end
    return lvl;
  endfunction

  // Frame sequencer: start, data, parity, error interval, guard
  always_comb begin
    state_d = state_q;
    dir_d = dir_q;
    tickCnt_d = tickCnt_q;
    slot_d = slot_q;
    shift_d = shift_q;
    parBad_d = parBad_q;
    errSeen_d = errSeen_q;
    driveLow_d = 1'b0;
    evParErr = 1'b0;
    evRxGood = 1'b0;
    evErrSig = 1'b0;
    evTxDone = 1'b0;
    txTaken = 1'b0;
    if (tick && state_q != ST_IDLE) begin
      tickCnt_d = bitEnd ? 9'h1 : tickCnt_q + 9'h1; // [R1]
      slot_d = bitEnd ? slot_q + 4'h1 : slot_q;
    end
    case (state_q)
      ST_IDLE: begin
        tickCnt_d = 9'h1;
        slot_d = 4'h0;
        errSeen_d = 1'b0;
        parBad_d = 1'b0;
        if (tick && txEn && txPending_q) begin
          state_d = ST_FRAME;
          dir_d = DIR_TX;
          shift_d = txBuf_q;
          txTaken = 1'b1;
        end else if (rxEn && !txEn && startEdge) begin
          state_d = ST_FRAME; // [R2]
          dir_d = DIR_RX;
        end
      end
      ST_FRAME: begin
        if (dir_q == DIR_TX) begin
          driveLow_d = !txBitLevel(slot_d, shift_q, oddPar);
        end else if (sampleNow && slot_q != 4'h0) begin
          if (slot_q <= 4'h8) begin
            shift_d = {lineSync_q, shift_q[7:1]}; // [R3]
          end else begin
            parBad_d = ^shift_q ^ lineSync_q ^ oddPar;
          end
        end
        if (bitEnd && slot_q == `SC_FRAME_BITS - 4'h1) begin
          state_d = ST_GUARD; // [R4]
          if (dir_q == DIR_RX) begin
            evParErr = parBad_q; // [R5]
            evRxGood = !parBad_q; // [R9]
          end
        end
      end
      ST_GUARD: begin
        if (dir_q == DIR_RX) begin
          // Pull low only after a bad parity; otherwise released
          driveLow_d = parBad_q && slot_d == `SC_ERR_SLOT; // [R19] [R10]
        end else if (sampleNow && slot_q == `SC_ERR_SLOT) begin
          errSeen_d = !lineSync_q; // [R19]
          evErrSig = !lineSync_q; // [R11] [R14]
        end
        if (bitEnd && slot_q == `SC_LAST_SLOT) begin
          if (dir_q == DIR_TX && errSeen_q) begin
            // Same byte goes again in the very next slot
            state_d = ST_FRAME; // [R13] [R20] [R16]
            slot_d = 4'h0;
            errSeen_d = 1'b0;
            driveLow_d = 1'b1;
          end else begin
            state_d = ST_IDLE;
            evTxDone = dir_q == DIR_TX; // [R15]
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      dir_q <= DIR_RX;
      tickCnt_q <= 9'h1;
      slot_q <= 4'h0;
      shift_q <= 8'h00;
      parBad_q <= 1'b0;
      errSeen_q <= 1'b0;
      driveLow_q <= 1'b0;
      linePrev_q <= 1'b1;
    end else begin
      state_q <= state_d;
      dir_q <= dir_d;
      tickCnt_q <= tickCnt_d;
      slot_q <= slot_d;
      shift_q <= shift_d;
      parBad_q <= parBad_d;
      errSeen_q <= errSeen_d;
      driveLow_q <= driveLow_d;
      linePrev_q <= linePrev_d;
    end
  end

  // Open-drain line: only ever pulls low
  assign dataOut = 1'b0;
  assign dataOe = driveLow_q;

  logic wrCtrl, wrStatus, wrTx;
  assign wrCtrl = regWrite && regAddr == `SC_OFS_CTRL;
  assign wrStatus = regWrite && regAddr == `SC_OFS_STATUS;
  assign wrTx = regWrite && regAddr == `SC_OFS_TXDATA;

  // Register file: a hardware set wins over a clear in the same cycle
  always_comb begin
    ctrl_d = wrCtrl ? regWdata[4:0] : ctrl_q;
    txBuf_d = wrTx ? regWdata : txBuf_q;
    txPending_d = wrTx | (txPending_q & ~txTaken);
    rx_data_reg_d = rx_data_reg_q;
    if (evParErr || evRxGood) begin
      rx_data_reg_d = shift_q; // [R18]
    end
    // Writing a new byte clears the end flag
    tx_end_flag_d = evTxDone | (tx_end_flag_q & ~wrTx); // [R15] [R13]
    rx_full_flag_d = evRxGood | (rx_full_flag_q & // [R7] [R9]
      ~(wrStatus & regWdata[`SC_ST_RX_FULL]));
    parity_error_flag_d = evParErr | (parity_error_flag_q & // [R5] [R8]
      ~(wrStatus & regWdata[`SC_ST_PAR_ERR])); // [R6]
    error_signal_flag_d = evErrSig | (error_signal_flag_q & // [R11]
      ~(wrStatus & regWdata[`SC_ST_ERR_SIG])); // [R12]
    rdata_d = 8'h00;
    if (regRead) begin
      case (regAddr)
        `SC_OFS_CTRL: rdata_d = {3'h0, ctrl_q};
        `SC_OFS_STATUS: begin
          rdata_d = {3'h0, state_q != ST_IDLE, error_signal_flag_q,
            parity_error_flag_q, rx_full_flag_q, tx_end_flag_q};
        end
        `SC_OFS_TXDATA: rdata_d = txBuf_q;
        `SC_OFS_RXDATA: rdata_d = rx_data_reg_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl_q <= `SC_CTRL_RESET;
      tx_end_flag_q <= `SC_TX_END_RESET;
      rx_full_flag_q <= 1'b0;
      parity_error_flag_q <= 1'b0;
      error_signal_flag_q <= 1'b0;
      txBuf_q <= 8'h00;
      txPending_q <= 1'b0;
      rx_data_reg_q <= 8'h00;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      tx_end_flag_q <= tx_end_flag_d;
      rx_full_flag_q <= rx_full_flag_d;
      parity_error_flag_q <= parity_error_flag_d;
      error_signal_flag_q <= error_signal_flag_d;
      txBuf_q <= txBuf_d;
      txPending_q <= txPending_d;
      rx_data_reg_q <= rx_data_reg_d;
      rdata_q <= rdata_d;
    end
  end

  assign regRdata = rdata_q;

  // Request outputs; there is no transmit-end request at all
  assign tx_empty_irq = tx_end_flag_q & ctrl_q[`SC_CTRL_TX_IRQ_EN]; // [R17]
  assign rx_full_irq = rx_full_flag_q & ctrl_q[`SC_CTRL_RX_IRQ_EN]; // [R9]
  assign comm_error_irq = (parity_error_flag_q | error_signal_flag_q) &
    ctrl_q[`SC_CTRL_RX_IRQ_EN]; // [R5] [R11]
endmodule // smart_card_char_retransmit

// [hw/sc_cfg.svh]
// Constants of the smart-card character unit: offsets, fields, resets,
// and bit timing counts. Included by the design modules.
`ifndef SC_CFG_SVH
`define SC_CFG_SVH

// Bit timing: basic-clock counts, frame slot numbers and the system-clock half divider
`define SC_ETU_TICKS 9'h174
`define SC_SAMPLE_TICK 9'h0ba
`define SC_FRAME_BITS 4'ha
`define SC_ERR_SLOT 4'ha
`define SC_LAST_SLOT 4'hb
`define SC_BASE_HALF_DIV 4'h2

// Register offsets on the plain register port
`define SC_OFS_CTRL 2'h0
`define SC_OFS_STATUS 2'h1
`define SC_OFS_TXDATA 2'h2
`define SC_OFS_RXDATA 2'h3

// Control register fields
`define SC_CTRL_TX_EN 0
`define SC_CTRL_RX_EN 1
`define SC_CTRL_TX_IRQ_EN 2
`define SC_CTRL_RX_IRQ_EN 3
`define SC_CTRL_ODD_PAR 4
`define SC_CTRL_RESET 5'h00

// Status register fields
`define SC_ST_TX_END 0
`define SC_ST_RX_FULL 1
`define SC_ST_PAR_ERR 2
`define SC_ST_ERR_SIG 3
`define SC_ST_BUSY 4
`define SC_TX_END_RESET 1'b1

`endif

// [hw/sc_pkg.sv]
// Types shared by the smart-card character unit modules.
// Assumes sc_cfg.svh is on the include path.
package sc_pkg;
  // Frame sequencer states, Gray coded along idle, frame, guard
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_FRAME = 2'h1,
    ST_GUARD = 2'h3
  } scState_t;

  // Direction of the frame in progress
  typedef enum logic {
    DIR_RX = 1'b0,
    DIR_TX = 1'b1
  } scDir_t;
endpackage

// [hw/sc_tick_if.sv]
// Carrier for the basic clock between the divider and the sequencer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface sc_tick_if;
  logic tick;
  logic cardClk;
  modport gen (output tick, output cardClk);
  modport use_end (input tick, input cardClk);
endinterface // sc_tick_if

// [hw/sc_base_clock.sv]
// Basic clock divider: a square card clock and a one-cycle tick on each
// of its rising edges. Assumes clk_sys and a synchronous low reset.
`timescale 1ns/1ps
`include "sc_cfg.svh"
module sc_base_clock
  import sc_pkg::*;
#(
  parameter logic [3:0] HALF_DIV = `SC_BASE_HALF_DIV
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Basic clock out
  sc_tick_if.gen tb
);
  logic [3:0] divCnt_q, divCnt_d;
  logic clkLvl_q, clkLvl_d;
  logic tick_q, tick_d;

  // Half-period counter toggles the card clock; tick marks the rise
  always_comb begin
    divCnt_d = divCnt_q + 4'h1;
    clkLvl_d = clkLvl_q;
    tick_d = 1'b0;
    if (divCnt_q >= HALF_DIV - 4'h1) begin
      divCnt_d = 4'h0;
      clkLvl_d = ~clkLvl_q;
      tick_d = ~clkLvl_q;
    end
  end

  // Divider registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      divCnt_q <= 4'h0;
      clkLvl_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      divCnt_q <= divCnt_d;
      clkLvl_q <= clkLvl_d;
      tick_q <= tick_d;
    end
  end

  assign tb.tick = tick_q;
  assign tb.cardClk = clkLvl_q;
endmodule // sc_base_clock

// [verif/smart_card_char_retransmit_properties.sv]
// Port checker for the smart-card character unit.
// Assumes one domain, clk_sys, with a synchronous low reset.
`timescale 1ns/1ps
module smart_card_char_retransmit_properties #(
  parameter logic [3:0] BASE_HALF_DIV = 4'h2,
  parameter logic [8:0] ETU_TICKS = 9'h174
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic [1:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  // Line, card clock and requests
  input wire logic dataOut,
  input wire logic dataOe,
  input wire logic cardClk,
  input wire logic tx_empty_irq,
  input wire logic rx_full_irq,
  input wire logic comm_error_irq
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // Longest legal pull: ten low slots of one frame, with margin
  localparam int OE_MAX = 11 * int'(ETU_TICKS) * 2 * int'(BASE_HALF_DIV);
  logic [4:0] gapQ;
  logic seenQ;
  int oeRun;

  // Cycles the device has held the line low without a break
  always_ff @(posedge clk_sys) begin
    oeRun <= (nrst && dataOe) ? oeRun + 1 : 0;
  end

  // Cycles since the last card clock rise
  always_ff @(posedge clk_sys) begin
    gapQ <= $rose(cardClk) ? 5'h1 : gapQ + 5'h1;
    seenQ <= nrst && (seenQ || $rose(cardClk));
  end

  clk_period_a: assert property ($rose(cardClk) && seenQ
    |-> gapQ == {BASE_HALF_DIV, 1'b0})
    else $error("card clock period wrong");
  clk_hold_a: assert property ($changed(cardClk) |=> $stable(cardClk))
    else $error("card clock glitch");
  pull_only_a: assert property (dataOut == 1'b0)
    else $error("line driven high");
  oe_on_tick_a: assert property ($changed(dataOe) |-> $past(cardClk))
    else $error("line change off basic clock");
  error_width_a: assert property ($rose(dataOe) |=> dataOe [*8])
    else $error("low pulse too short");
  oe_release_a: assert property (dataOe |-> oeRun < OE_MAX)
    else $error("line held past a frame");
  read_idle_a: assert property (!$past(regRead) |-> regRdata == 8'h00)
    else $error("read data outside read cycle");
  txend_clear_a: assert property (regWrite && regAddr == 2'h2
    |=> !tx_empty_irq)
    else $error("end request kept after data write");

  // Main scenarios
  cover property ($rose(comm_error_irq));
  cover property ($rose(rx_full_irq));
  cover property ($rose(tx_empty_irq));
endmodule // smart_card_char_retransmit_properties

bind smart_card_char_retransmit smart_card_char_retransmit_properties
  #(.BASE_HALF_DIV(BASE_HALF_DIV), .ETU_TICKS(ETU_TICKS))
  props (.clk_sys(clk_sys), .nrst(nrst),
  .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .dataOut(dataOut), .dataOe(dataOe),
  .cardClk(cardClk), .tx_empty_irq(tx_empty_irq),
  .rx_full_irq(rx_full_irq), .comm_error_irq(comm_error_irq));

// [verif/sc_card_model.sv]
// Behavioural card on the shared data line, timed by the card clock.
// Assumes the bench resolves the line with a pull-up.
`timescale 1ns/1ps
module sc_card_model #(
  parameter int ETU = 12
) (
  // Card clock and line
  input wire logic cardClk,
  input wire logic line,
  // Card pull and received byte
  output logic pull,
  output logic [7:0] got,
  output logic gotT
);
  logic tx = 1'b0;
  logic [9:0] s;
  int naks = 0;
  initial pull = 1'b0;
  initial gotT = 1'b0;

  // Send one frame, parity spoiled on request, then sit out the guard
  task automatic sendByte(input logic [7:0] b, input logic bad);
    logic [9:0] f;
    f = {^b ^ bad, b, 1'b0};
    tx = 1'b1;
    for (int i = 0; i < 10; i++) begin
      pull = !f[i];
      repeat (ETU) @(posedge cardClk);
    end
    pull = 1'b0;
    repeat (2 * ETU) @(posedge cardClk);
    tx = 1'b0;
  endtask

  // Listen to device frames, reject the first naks of them
  always begin
    @(posedge cardClk);
    if (!line && !tx) begin
      repeat (ETU / 2 - 1) @(posedge cardClk);
      for (int i = 0; i < 10; i++) begin
        s = {line, s[9:1]};
        if (i < 9) repeat (ETU) @(posedge cardClk);
      end
      got = s[8:1];
      gotT = !gotT;
      repeat (ETU / 2 + 1) @(posedge cardClk);
      if (naks > 0) begin
        pull = 1'b1;
        naks--;
      end
      repeat (ETU) @(posedge cardClk);
      pull = 1'b0;
      repeat (ETU - 1) @(posedge cardClk);
    end
  end
endmodule // sc_card_model

// [verif/smart_card_char_retransmit_tb_top.sv]
// Self-checking bench: register port driver, card model, result queue.
// Assumes a pull-up on the data line and a shortened bit time.
`timescale 1ns/1ps
module smart_card_char_retransmit_tb_top;
  logic clk_sys, nrst, regWrite, regRead;
  logic rdPend = 1'b0;
  int oeCnt = 0;
  int oeMark = 0;
  logic [1:0] regAddr;
  logic [7:0] regWdata, regRdata, b, got;
  logic dataOut, dataOe, cardClk, txIrq, rxIrq, errIrq, line, pull, gotT;
  logic [2:0] irqs;
  logic [7:0] expQ[$];
  int errorCnt = 0;
  int samplesChecked = 0;
  int seed = 82;

  assign line = !(dataOe || pull);
  assign irqs = {errIrq, rxIrq, txIrq};

  smart_card_char_retransmit #(.BASE_HALF_DIV(4'h4), .ETU_TICKS(9'h00c),
    .SAMPLE_TICK(9'h006)) DUT (.clk_sys(clk_sys), .nrst(nrst),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .dataIn(line),
    .dataOut(dataOut), .dataOe(dataOe), .cardClk(cardClk),
    .tx_empty_irq(txIrq), .rx_full_irq(rxIrq), .comm_error_irq(errIrq));
  sc_card_model #(.ETU(12)) card (.cardClk(cardClk), .line(line),
    .pull(pull), .got(got), .gotT(gotT));

  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
    input string what);
    samplesChecked++;
    if (seen !== exp) begin
      errorCnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    expQ.push_back(e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic waitIrq(input logic [2:0] m);
    int n;
    n = 0;
    while ((irqs & m) == 3'h0 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 4000) begin
      errorCnt++;
      giveVerdict();
    end
  endtask

  // Results: read data one cycle after the strobe, bytes at the card
  always @(posedge clk_sys) begin
    if (rdPend)
      check(regRdata, expQ.pop_front(), "read data");
    rdPend <= regRead;
    if (dataOe)
      oeCnt <= oeCnt + 1;
  end
  // Only toggles after reset are bytes; the first settle is not
  always @(gotT)
    if (nrst === 1'b1)
      check(got, expQ.pop_front(), "card byte");

  initial begin
    {nrst, regWrite, regRead} = 3'h0;
    regAddr = 2'h0;
    regWdata = 8'h00;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd(2'h1, 8'h01);
    rd(2'h0, 8'h00);
    $display("test reset values done");
    wr(2'h0, 8'h0d);
    for (int k = 0; k < 3; k += 2) begin
      b = 8'($random(seed));
      card.naks = k;
      wr(2'h2, b);
      repeat (20) @(posedge clk_sys);
      rd(2'h1, 8'h10);
      repeat (k + 1) expQ.push_back(b);
      waitIrq(3'h1);
      rd(2'h1, k ? 8'h09 : 8'h01);
      check({7'h0, errIrq}, {7'h0, k != 0}, "error request");
      wr(2'h1, 8'h08);
      $display("test transmit with %0d rejections done", k);
    end
    wr(2'h0, 8'h0a);
    for (int k = 0; k < 2; k++) begin
      b = 8'($random(seed));
      oeMark = oeCnt;
      @(posedge cardClk);
      card.sendByte(b, k[0]);
      // Device guard ends a tick after the card's; let it go idle
      repeat (16) @(posedge clk_sys);
      check({6'h0, errIrq, rxIrq}, k ? 8'h02 : 8'h01, "rx requests");
      check({7'h0, oeCnt != oeMark}, {7'h0, k[0]}, "error pulse");
      rd(2'h1, k ? 8'h05 : 8'h03);
      rd(2'h3, b);
      wr(2'h1, 8'h06);
      $display("test receive frame %0d done", k);
    end
    repeat (4) @(posedge clk_sys);
    giveVerdict();
  end
endmodule // smart_card_char_retransmit_tb_top
